// ### logic/prog_ctrl_defs.vh
// constants for the serial eeprom programming control block
`ifndef PROG_CTRL_DEFS_VH
`define PROG_CTRL_DEFS_VH
`define ADDR_W 8
`define DATA_W 16
`define WORDS 256
`define OP_EXT 2'h0
`define OP_WRITE 2'h1
`define OP_READ 2'h2
`define OP_ERASE 2'h3
`define EXT_WRITE_OFF 2'h0
`define EXT_WRITE_ALL 2'h1
`define EXT_ERASE_ALL 2'h2
`define EXT_WEN 2'h3
`define HDR_BITS 10
`define FRAME_BITS 26
`define CLK_PERIOD_NS 10
`define PROGRAM_TIME_NS 10000000
`define PROGRAM_CYCLES ((`PROGRAM_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ERASED_WORD 16'hffff
`endif

// ### logic/prog_timer.v
// self-timed programming cycle counter
`timescale 1ns/10ps
module prog_timer #(
    parameter CYCLES = 1000000
) (
    input wire clk,
    input wire nrst,
    input wire start,
    output reg busy_reg
);
    reg [31:0] count_reg;
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count_reg <= 32'h0;
            busy_reg <= 1'b0;
        end else if (start && !busy_reg) begin
            count_reg <= CYCLES - 1;
            busy_reg <= 1'b1;
        end else if (busy_reg) begin
            if (count_reg == 32'h0) begin
                busy_reg <= 1'b0;
            end else begin
                count_reg <= count_reg - 32'h1;
            end
        end
    end
endmodule // prog_timer

// ### logic/eeprom_prog_ctrl.v
// serial eeprom instruction receiver, programming cycle and ready/busy output
// Function
// [RULE1] write and write-all need latch set
// [RULE2] master drops select after last data bit
// [RULE3] select falling edge starts programming
// [RULE4] busy refuses instructions until cycle ends
// [RULE5] master waits deselect time before polling
// [RULE6] output low while busy, high when ready
// [RULE7] status shown without serial clock edges
// [RULE8] master avoids commands while busy
// [RULE9] master sends write-disable after writes
// [RULE10] write-all programs every word with pattern
// [RULE11] write-disable clears latch at select fall
// [RULE12] latch never gates reading
// [RULE13] erase sets addressed word to ones
// [RULE14] master drops select after last address bit
// [RULE15] erase-all sets whole array to ones
// [RULE16] writes overwrite without prior erase
// [RULE17] output high impedance while select low
// [RULE18] select toggling leaves programming unaffected
// [RULE19] ready shown until start bit clocked
// [RULE20] start bit begins new command
// [RULE21] latch cleared at reset, set by enable
// [RULE22] leading zeros skipped until start bit
// [RULE23] opcode, address, data msb first
// [RULE24] opcode and address msbs decode instruction
// [RULE25] programming time counted by own clock
`timescale 1ns/10ps
`include "prog_ctrl_defs.vh"
module eeprom_prog_ctrl #(
    parameter PROGRAM_CYCLES = `PROGRAM_CYCLES,
    parameter ADDR_W = `ADDR_W,
    parameter DATA_W = `DATA_W
) (
    input wire clk,
    input wire nrst,
    input wire chip_select,
    input wire serial_clock,
    input wire serial_in,
    output reg serial_out,
    output reg serial_out_oe_n,
    output reg write_enable_reg,
    output reg busy,
    output reg [ADDR_W-1:0] array_addr,
    output reg [DATA_W-1:0] array_wdata,
    output reg array_we,
    output reg array_all
);

    // synchroniser stages: _m catches the pin, _s is the settled copy,
    // _d is the settled copy one clock older, used for edge finding
    reg cs_m_reg;
    reg cs_s_reg;
    reg cs_d_reg;
    reg sclk_m_reg;
    reg sclk_s_reg;
    reg sclk_d_reg;
    reg sdin_m_reg;
    reg sdin_s_reg;

    // instruction receiver state
    reg started_reg;
    reg [4:0] nbits_reg;
    reg [1:0] op_reg;
    reg [ADDR_W-1:0] addr_reg;
    reg [DATA_W-1:0] data_reg;

    // ready indicator and the operation handed to the timer
    reg ready_show_reg;
    reg pending_reg;
    reg [ADDR_W-1:0] p_addr_reg;
    reg [DATA_W-1:0] p_data_reg;
    reg p_all_reg;

    // timer handshake
    wire timer_busy;
    wire launch_start;

    // decoded events and frame state
    wire cs_rise;
    wire cs_fall;
    wire sclk_rise;
    wire [1:0] ext;
    wire is_write;
    wire is_erase;
    wire is_write_all;
    wire is_erase_all;
    wire is_wen;
    wire is_write_off;
    wire hdr_done;
    wire data_done;
    wire prog_ok;
    wire data_frame;
    wire addr_frame;
    wire launch;
    wire start_seen;
    wire shift_op;
    wire shift_addr;
    wire shift_data;

    // edges come from the settled stages only, never from the catch stage
    assign cs_rise = cs_s_reg && !cs_d_reg;
    assign cs_fall = !cs_s_reg && cs_d_reg;
    // serial clock activity counts only while selected
    assign sclk_rise = sclk_s_reg && !sclk_d_reg && cs_s_reg;

    // [RULE24] opcode and address msbs decode
    assign ext = addr_reg[ADDR_W-1:ADDR_W-2];
    assign is_write = (op_reg == `OP_WRITE);
    assign is_erase = (op_reg == `OP_ERASE);
    assign is_write_all = (op_reg == `OP_EXT) && (ext == `EXT_WRITE_ALL);
    assign is_erase_all = (op_reg == `OP_EXT) && (ext == `EXT_ERASE_ALL);
    assign is_wen = (op_reg == `OP_EXT) && (ext == `EXT_WEN);
    assign is_write_off = (op_reg == `OP_EXT) && (ext == `EXT_WRITE_OFF);

    // data frames need all data bits, address-only frames stop after the header;
    // a shorter frame, or an address-only frame past the header, does nothing when select falls
    assign hdr_done = started_reg && (nbits_reg == 5'd`HDR_BITS);
    assign data_done = started_reg && (nbits_reg == 5'd`FRAME_BITS);

    // [RULE4] nothing new while the timer runs
    // the pending cycle counts as busy too, so two launches can never overlap
    assign prog_ok = !timer_busy && !pending_reg;
    assign data_frame = (is_write || is_write_all) && data_done;
    // [RULE15] erase-all launches like an erase
    assign addr_frame = (is_erase || is_erase_all) && hdr_done;
    // [RULE1] programming only with the latch set
    assign launch = cs_fall && prog_ok && write_enable_reg && (data_frame || addr_frame);

    // [RULE22] a one while idle is the start bit
    // start bits are refused while busy, so the status stays shown to the poller
    assign start_seen = sclk_rise && !started_reg && sdin_s_reg && !timer_busy;
    // [RULE23] opcode, address, data msb first
    assign shift_op = (nbits_reg < 5'h2);
    assign shift_addr = !shift_op && (nbits_reg < 5'd`HDR_BITS);
    assign shift_data = !shift_op && !shift_addr;

    // [RULE25] cycle count from the own clock
    prog_timer #(
        .CYCLES(PROGRAM_CYCLES)
    ) u_timer (
        .clk(clk),
        .nrst(nrst),
        .start(launch_start),
        .busy_reg(timer_busy)
    );
    // the timer starts one clock after the capture, so address and data are held
    assign launch_start = pending_reg;

    // pins come from another domain: two flip-flops before use
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cs_m_reg <= 1'b0;
            cs_s_reg <= 1'b0;
            cs_d_reg <= 1'b0;
        end else begin
            cs_m_reg <= chip_select;
            cs_s_reg <= cs_m_reg;
            cs_d_reg <= cs_s_reg;
        end
    end

    // serial clock pin; idle low, so no false edge follows reset
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sclk_m_reg <= 1'b0;
            sclk_s_reg <= 1'b0;
            sclk_d_reg <= 1'b0;
        end else begin
            sclk_m_reg <= serial_clock;
            sclk_s_reg <= sclk_m_reg;
            sclk_d_reg <= sclk_s_reg;
        end
    end

    // serial data pin; its level is used only at a serial clock edge
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sdin_m_reg <= 1'b0;
            sdin_s_reg <= 1'b0;
        end else begin
            sdin_m_reg <= serial_in;
            sdin_s_reg <= sdin_m_reg;
        end
    end

    // instruction shift logic
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            started_reg <= 1'b0;
            nbits_reg <= 5'h0;
            op_reg <= 2'h0;
            addr_reg <= {ADDR_W{1'b0}};
            data_reg <= {DATA_W{1'b0}};
        end else if (cs_rise || !cs_s_reg) begin
            // [RULE20] select low resets the shifter
            started_reg <= 1'b0;
            nbits_reg <= 5'h0;
        end else if (start_seen) begin
            started_reg <= 1'b1;
        end else if (sclk_rise && started_reg && (nbits_reg != 5'd`FRAME_BITS)) begin
            // bits past a full frame are dropped; the counter saturates
            nbits_reg <= nbits_reg + 5'h1;
            if (shift_op) begin
                op_reg <= {op_reg[0], sdin_s_reg};
            end
            if (shift_addr) begin
                addr_reg <= {addr_reg[ADDR_W-2:0], sdin_s_reg};
            end
            if (shift_data) begin
                data_reg <= {data_reg[DATA_W-2:0], sdin_s_reg};
            end
        end
    end

    // write-enable latch
    // [RULE12] latch never gates reading
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            // [RULE21] programming disabled at power-up
            write_enable_reg <= 1'b0;
        end else if (cs_fall && hdr_done && prog_ok) begin
            // [RULE11] disable takes effect on select fall
            if (is_write_off) begin
                write_enable_reg <= 1'b0;
            end else if (is_wen) begin
                write_enable_reg <= 1'b1;
            end
        end
    end

    // capture the operation at select fall
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pending_reg <= 1'b0;
            p_addr_reg <= {ADDR_W{1'b0}};
            p_data_reg <= {DATA_W{1'b0}};
            p_all_reg <= 1'b0;
        end else if (launch) begin
            // [RULE3] select fall starts the cycle
            pending_reg <= 1'b1;
            p_addr_reg <= addr_reg;
            // [RULE13] erase loads all ones
            p_data_reg <= (is_erase || is_erase_all) ? `ERASED_WORD : data_reg;
            // [RULE10] whole-array operations
            p_all_reg <= is_write_all || is_erase_all;
        end else begin
            pending_reg <= 1'b0;
        end
    end

    // array strobe; writes overwrite directly with no erase step
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            array_addr <= {ADDR_W{1'b0}};
            array_wdata <= {DATA_W{1'b0}};
            array_we <= 1'b0;
            array_all <= 1'b0;
            busy <= 1'b0;
        end else begin
            // [RULE16] direct overwrite
            array_we <= pending_reg;
            array_addr <= p_addr_reg;
            array_wdata <= p_data_reg;
            array_all <= p_all_reg;
            // [RULE4] busy until timer expires
            busy <= timer_busy || pending_reg;
        end
    end

    // ready/busy indicator driven to the serial output pin
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ready_show_reg <= 1'b0;
            serial_out <= 1'b0;
            serial_out_oe_n <= 1'b1;
        end else begin
            if (launch) begin
                ready_show_reg <= 1'b1;
            end else if (start_seen) begin
                // [RULE19] start bit clears the indicator
                ready_show_reg <= 1'b0;
            end else if (cs_fall && prog_ok) begin
                // [RULE20] select low after completion clears it as well;
                // while busy a fall leaves it, so polling may toggle select
                ready_show_reg <= 1'b0;
            end
            // [RULE17] tri-state while select low
            // [RULE18] select toggling leaves timer alone
            // [RULE7] no serial clock needed
            serial_out_oe_n <= !(cs_s_reg && (ready_show_reg || launch));
            // [RULE6] low while busy, high when ready
            serial_out <= !(timer_busy || pending_reg);
        end
    end
endmodule // eeprom_prog_ctrl

// ### dv/eeprom_prog_ctrl_sva.sv
// assertion checker for the eeprom programming control block
`timescale 1ns/10ps
module eeprom_prog_ctrl_sva #(parameter PROGRAM_CYCLES = 50) (
    input wire clk, nrst, chip_select, serial_clock, serial_in,
    input wire serial_out, serial_out_oe_n, write_enable_reg, busy,
    input wire [7:0] array_addr,
    input wire [15:0] array_wdata,
    input wire array_we, array_all
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    logic [31:0] busy_cnt_reg;
    // counting kept outside the property so the long busy time stays cheap
    always @(posedge clk or negedge nrst) begin
        if (!nrst) busy_cnt_reg <= 0;
        else busy_cnt_reg <= busy ? busy_cnt_reg + 1 : 0;
    end
    sequence s_shown;
        (!busy)[*3] ##0 !serial_out_oe_n;
    endsequence
    sequence s_poll;
        busy && $rose(chip_select) ##1 (chip_select && !serial_clock)[*7];
    endsequence
    a_oe_deselect: assert property ((!chip_select)[*5] |-> serial_out_oe_n)
        else $error("output driven while deselected");
    a_we_latch: assert property (array_we |-> write_enable_reg)
        else $error("programming without write enable");
    a_we_not_busy: assert property (array_we |-> !$past(busy, 2))
        else $error("programming started while busy");
    a_busy_follows: assert property (array_we |-> ##[0:2] busy)
        else $error("no busy after programming strobe");
    a_busy_length: assert property ($fell(busy) |-> busy_cnt_reg == PROGRAM_CYCLES + 1)
        else $error("wrong programming time");
    a_busy_low: assert property (busy && !serial_out_oe_n |-> !serial_out)
        else $error("ready shown while busy");
    a_ready_high: assert property (s_shown |-> serial_out)
        else $error("busy shown while idle");
    a_poll_noclk: assert property (s_poll |-> !serial_out_oe_n)
        else $error("status not shown without clock");
    a_latch_edge: assert property ($changed(write_enable_reg) |-> !chip_select)
        else $error("latch changed while selected");
endmodule // eeprom_prog_ctrl_sva

// ### dv/serial_master.sv
// serial bus master model driving select, clock and data
`timescale 1ns/10ps
module serial_master (
    input wire clk,
    output reg chip_select,
    output reg serial_clock,
    output reg serial_in
);
    initial begin
        chip_select = 1'b0;
        serial_clock = 1'b0;
        serial_in = 1'b0;
    end
    task send_bit(input logic b);
        serial_in <= b;
        repeat (8) @(posedge clk);
        serial_clock <= 1'b1;
        repeat (8) @(posedge clk);
        serial_clock <= 1'b0;
    endtask
    task select(input logic s);
        @(posedge clk);
        chip_select <= s;
    endtask
    task frame(input logic [28:0] v, input int n);
        select(1'b1);
        repeat (4) @(posedge clk);
        for (int i = n - 1; i >= 0; i--) send_bit(v[i]);
        chip_select <= 1'b0;
        // released data line must not look valid
        serial_in <= ~serial_in;
        repeat (10) @(posedge clk);
    endtask
endmodule // serial_master

// ### dv/tb_top.sv
// self-checking bench for the eeprom programming control block
`timescale 1ns/10ps
module tb_top;
    localparam int PROGRAM_CYCLES = 50;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    wire chip_select, serial_clock, serial_in, serial_out, serial_out_oe_n;
    wire write_enable_reg, busy, array_we, array_all;
    wire [7:0] array_addr;
    wire [15:0] array_wdata;
    int bad_count = 0, total_checks = 0, we_count = 0, i;
    logic [24:0] seen;
    initial forever #5 clk = ~clk;
    serial_master serial_master_inst (.clk, .chip_select, .serial_clock, .serial_in);
    eeprom_prog_ctrl #(.PROGRAM_CYCLES(PROGRAM_CYCLES)) eeprom_prog_ctrl_inst (.clk, .nrst,
        .chip_select, .serial_clock, .serial_in, .serial_out, .serial_out_oe_n,
        .write_enable_reg, .busy, .array_addr, .array_wdata, .array_we, .array_all);
    always @(posedge clk) if (array_we) begin
        we_count <= we_count + 1;
        seen <= {array_all, array_addr, array_wdata};
    end
    task tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // bounded waits read the live signal each clock
    task wait_idle;
        for (i = 0; i < 300 && busy !== 1'b0; i++) @(posedge clk);
        if (i == 300) begin
            bad_count++;
            tally_and_finish;
        end
    endtask
    task wait_ready;
        for (i = 0; i < 300 && serial_out !== 1'b1; i++) @(posedge clk);
        if (i == 300) begin
            bad_count++;
            tally_and_finish;
        end
    endtask
    // waits for idle, sends one frame, then judges the program pulses
    task op(input logic [28:0] v, input int n, input int pulses, input logic [24:0] e);
        wait_idle;
        we_count = 0;
        serial_master_inst.frame(v, n);
        chk(we_count, pulses);
        if (pulses > 0) begin
            chk(seen[24], e[24]);
            chk(seen[15:0], e[15:0]);
            if (!e[24]) chk(seen[23:16], e[23:16]);
        end
    endtask
    // polls during programming, then a start bit clears ready and opens an erase
    task poll_then_erase;
        serial_master_inst.select(1'b1);
        repeat (6) @(posedge clk);
        chk({serial_out_oe_n, serial_out}, 2'b00);
        serial_master_inst.select(1'b0);
        repeat (6) @(posedge clk);
        chk(serial_out_oe_n, 1);
        serial_master_inst.select(1'b1);
        wait_ready;
        repeat (20) @(posedge clk);
        chk({busy, serial_out_oe_n, serial_out}, 3'b001);
        we_count = 0;
        serial_master_inst.send_bit(1'b1);
        repeat (6) @(posedge clk);
        chk(serial_out_oe_n, 1);
        for (int k = 9; k >= 0; k--) serial_master_inst.send_bit((k > 7) ? 1'b1 : ~k[0]);
        serial_master_inst.select(1'b0);
        repeat (10) @(posedge clk);
        chk({we_count[1:0], seen}, {2'd1, 1'b0, 8'h55, 16'hffff});
    endtask
    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        chk(write_enable_reg, 0);
        op({1'b1, 2'h1, 8'h5a, 16'h1234}, 27, 0, 0);
        op(13'h04c0, 13, 0, 0);
        chk(write_enable_reg, 1);
        op({1'b1, 2'h1, 8'h5a, 16'h1234}, 27, 1, {1'b0, 8'h5a, 16'h1234});
        poll_then_erase;
        op({1'b1, 2'h1, 8'h55, 16'h00f0}, 27, 1, {1'b0, 8'h55, 16'h00f0});
        op({1'b1, 2'h0, 8'h40, 16'hbeef}, 27, 1, {1'b1, 8'h0, 16'hbeef});
        op({1'b1, 2'h0, 8'h80}, 11, 1, {1'b1, 8'h0, 16'hffff});
        op({1'b1, 2'h0, 8'h00}, 11, 0, 0);
        chk(write_enable_reg, 0);
        op({1'b1, 2'h0, 8'h40, 16'hbeef}, 27, 0, 0);
        tally_and_finish;
    end
endmodule // tb_top
bind eeprom_prog_ctrl eeprom_prog_ctrl_sva #(.PROGRAM_CYCLES(PROGRAM_CYCLES)) sva_inst (.clk,
    .nrst, .chip_select, .serial_clock, .serial_in, .serial_out, .serial_out_oe_n,
    .write_enable_reg, .busy, .array_addr, .array_wdata, .array_we, .array_all);
